// [gsc_pkg.sv]
// Package for gate supply fault and commutation control
package gsc_pkg;
  // ****************************************
  // Fault flag indices
  // ****************************************
  localparam int NUM_FAULTS = 5;
  localparam int FLT_LOW_UV = 0;
  localparam int FLT_LOW_OV = 1;
  localparam int FLT_HIGH_UV = 2;
  localparam int FLT_HIGH_OV_REL = 3;
  localparam int FLT_HIGH_OV_ABS = 4;
  localparam logic [4:0] FLAGS_CLEAR = 5'h1F;
  localparam logic [4:0] PIN_EN_RESET = 5'h00;
  localparam logic [2:0] PHASE_OFF = 3'h0;
  // ****************************************
  // Drive methods
  // ****************************************
  typedef enum logic [0:0]
  {
    GSC_DRIVE_PWM  = 1'b0,
    GSC_DRIVE_COMM = 1'b1
  } gsc_drive_t;
endpackage : gsc_pkg

// [gsc_if.sv]
// Interface carrying live fault comparator levels
`timescale 1ns/1ps
`default_nettype none
interface gsc_flt_if;
  import gsc_pkg::*;
  logic [NUM_FAULTS-1:0] active;
  modport src (output active);
  modport dst (input active);
endinterface : gsc_flt_if
`default_nettype wire

// [gsc_sync.sv]
// Two-stage synchroniser for the comparator inputs
`timescale 1ns/1ps
`default_nettype none
module gsc_sync
  import gsc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [NUM_FAULTS-1:0] cmp_raw,
  gsc_flt_if.src                     flt
);
  logic [NUM_FAULTS-1:0] meta_r;
  logic [NUM_FAULTS-1:0] meta_nxt;
  logic [NUM_FAULTS-1:0] sync_r;
  logic [NUM_FAULTS-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = cmp_raw;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign flt.active = sync_r;
endmodule : gsc_sync
`default_nettype wire

// [gsc_top.sv]
// Gate supply fault flags, alarm pin and drive method select
`timescale 1ns/1ps
`default_nettype none
module gsc_top
  import gsc_pkg::*;
#(
  parameter int NF = NUM_FAULTS
)
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   global_powersave_release,
  input  wire logic                   pump_regulator_powersave_release,
  input  wire logic                   pump_powersave_release,
  input  wire logic [NF-1:0]          cmp_fault,
  input  wire logic [NF-1:0]          fault_pin_enable_one,
  input  wire logic                   status_clear,
  input  wire logic                   drive_method_select,
  input  wire logic                   drive_method_write,
  input  wire logic [2:0]             pwm_high_in,
  input  wire logic [2:0]             pwm_low_in,
  input  wire logic [2:0]             energized_high,
  input  wire logic [2:0]             energized_low,
  output logic                        pump_enable,
  output logic [NF-1:0]               fault_status_one,
  output logic [NF-1:0]               fault_live_monitor_one,
  output logic                        alarm_n,
  output gsc_pkg::gsc_drive_t         drive_method,
  output logic [2:0]                  gate_high_out,
  output logic [2:0]                  gate_low_out
);
  import gsc_pkg::*;

  // ****************************************
  // Comparator synchronisation
  // ****************************************
  gsc_flt_if flt ();

  gsc_sync u_sync
  (
    .clk     (clk),
    .srst    (srst),
    .cmp_raw (cmp_fault),
    .flt     (flt.src)
  );

  // ****************************************
  // Fault flags and alarm
  // ****************************************
  logic [NF-1:0] status_r;
  logic [NF-1:0] status_nxt;
  logic [NF-1:0] pin_hit;
  logic          alarm_n_r;
  logic          alarm_n_nxt;
  logic          pump_en_r;
  logic          pump_en_nxt;
  logic [NF-1:0] live_n;

  assign live_n = ~flt.active;

  always_comb
  begin
    status_nxt = status_r;
    // Clear releases flags; live fault wins
    if (status_clear)
    begin
      status_nxt = FLAGS_CLEAR;
    end
    status_nxt = status_nxt & live_n;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status_r <= FLAGS_CLEAR;
    end
    else
    begin
      status_r <= status_nxt;
    end
  end

  // ****************************************
  // Alarm pin and pump enable
  // ****************************************
  genvar gi;

  for (gi = 0; gi < NF; gi++)
  begin : g_pin
    assign pin_hit[gi] = fault_pin_enable_one[gi] & ~status_nxt[gi];
  end

  always_comb
  begin
    alarm_n_nxt = ~|pin_hit;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      alarm_n_r <= 1'b1;
    end
    else
    begin
      alarm_n_r <= alarm_n_nxt;
    end
  end

  always_comb
  begin
    pump_en_nxt = global_powersave_release & pump_regulator_powersave_release
                  & pump_powersave_release;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pump_en_r <= 1'b0;
    end
    else
    begin
      pump_en_r <= pump_en_nxt;
    end
  end

  assign fault_status_one       = status_r;
  assign fault_live_monitor_one = live_n;
  assign alarm_n                = alarm_n_r;
  assign pump_enable            = pump_en_r;

  // ****************************************
  // Gate pattern per phase
  // ****************************************
  logic [2:0] comm_high;
  logic [2:0] comm_low;
  genvar      gp;

  for (gp = 0; gp < $bits(pwm_high_in); gp++)
  begin : g_phase
    assign comm_high[gp] = pwm_high_in[gp] & energized_high[gp];
    assign comm_low[gp]  = energized_low[gp] & ~energized_high[gp];
  end

  // ****************************************
  // Drive method and gate outputs
  // ****************************************
  gsc_drive_t method_r;
  gsc_drive_t method_nxt;
  logic [2:0] high_r;
  logic [2:0] high_nxt;
  logic [2:0] low_r;
  logic [2:0] low_nxt;

  always_comb
  begin
    method_nxt = method_r;
    if (drive_method_write)
    begin
      method_nxt = gsc_drive_t'(drive_method_select);
    end
    case (method_r)
      GSC_DRIVE_COMM:
      begin
        high_nxt = comm_high;
        low_nxt  = comm_low;
      end
      default:
      begin
        high_nxt = pwm_high_in;
        low_nxt  = pwm_low_in;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      method_r <= GSC_DRIVE_PWM;
      high_r   <= PHASE_OFF;
      low_r    <= PHASE_OFF;
    end
    else
    begin
      method_r <= method_nxt;
      high_r   <= high_nxt;
      low_r    <= low_nxt;
    end
  end

  assign drive_method  = method_r;
  assign gate_high_out = high_r;
  assign gate_low_out  = low_r;
endmodule : gsc_top
`default_nettype wire

// [gsc_monitor.sv]
// Checker for gate supply flags and drive select
`timescale 1ns/1ps
`default_nettype none
module gsc_monitor
  import gsc_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [4:0] cmp_fault,
  input wire logic [4:0] fault_pin_enable_one,
  input wire logic       status_clear,
  input wire logic       drive_method_select,
  input wire logic       drive_method_write,
  input wire logic [2:0] pwm_high_in,
  input wire logic [2:0] energized_high,
  input wire logic [4:0] fault_live_monitor_one,
  input wire logic [4:0] fault_status_one,
  input wire logic       alarm_n,
  input wire gsc_drive_t drive_method,
  input wire logic [2:0] gate_high_out,
  input wire logic [2:0] gate_low_out
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_live;
    !$past(srst) && !$past(srst, 2) |->
      fault_live_monitor_one == ~$past(cmp_fault, 2);
  endproperty
  a_live: assert property (p_live) else $error("live flag missed");
  sequence s_fault_in;
    cmp_fault != 5'h00;
  endsequence
  sequence s_flag_low;
    ##3 (fault_status_one & $past(cmp_fault, 3)) == 5'h00;
  endsequence
  property p_stat;
    s_fault_in |-> s_flag_low;
  endproperty
  a_stat: assert property (p_stat) else $error("status missed");
  property p_alarm;
    !$past(srst) |->
      alarm_n == !(|(~fault_status_one & $past(fault_pin_enable_one)));
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not raised");
  property p_quiet;
    fault_pin_enable_one == 5'h00 |=> alarm_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("masked alarm");
  property p_rst;
    $fell(srst) |-> drive_method == GSC_DRIVE_PWM;
  endproperty
  a_rst: assert property (p_rst) else $error("reset mode");
  property p_wr;
    drive_method_write |=> drive_method == gsc_drive_t'(drive_method_select);
  endproperty
  a_wr: assert property (p_wr) else $error("mode write");
  property p_split;
    drive_method == GSC_DRIVE_COMM |=> (gate_high_out & gate_low_out) == 3'h0;
  endproperty
  a_split: assert property (p_split) else $error("both switches on");
  property p_mask;
    drive_method == GSC_DRIVE_COMM |=>
      gate_high_out == ($past(pwm_high_in) & $past(energized_high));
  endproperty
  a_mask: assert property (p_mask) else $error("chop mask");
endmodule : gsc_monitor
bind gsc_top gsc_monitor u_mon (.*);
`default_nettype wire

// [gsc_host.sv]
// Host model releasing power save in order
`timescale 1ns/1ps
`default_nettype none
module gsc_host
(
  input  wire logic clk,
  input  wire logic srst,
  output var logic  all_rel,
  output var logic  reg_rel,
  output var logic  pump_rel
);
  initial
  begin
    all_rel = 1'b0;
    reg_rel = 1'b0;
    pump_rel = 1'b0;
    for (int i = 0; i < 64 && srst; i++)
      @(posedge clk);
    @(negedge clk) all_rel = 1'b1;
    @(negedge clk) reg_rel = 1'b1;
    @(negedge clk) pump_rel = 1'b1;
  end
endmodule : gsc_host
`default_nettype wire

// [test_gsc_top.sv]
// Self-checking bench for gsc_top
`timescale 1ns/1ps
`default_nettype none
module test_gsc_top;
  import gsc_pkg::*;
  logic clk = 1'b0, srst = 1'b1, sclr = 1'b0, dsel = 1'b0, dwr = 1'b0;
  logic ga, gr, gp, pe, an;
  logic [4:0] cmp = 5'h00, en = 5'h00, st, lv, f;
  logic [2:0] ph = 3'h0, pl = 3'h0, eh = 3'h0, el = 3'h0, gh, gl;
  logic [31:0] seed = 32'hF, r;
  gsc_drive_t dm;
  int n_errors = 0, comparisons = 0;
  always #2 clk = ~clk;
  gsc_host host (.clk(clk), .srst(srst), .all_rel(ga), .reg_rel(gr), .pump_rel(gp));
  gsc_top uut (.clk(clk), .srst(srst), .global_powersave_release(ga),
    .pump_regulator_powersave_release(gr), .pump_powersave_release(gp), .cmp_fault(cmp),
    .fault_pin_enable_one(en), .status_clear(sclr), .drive_method_select(dsel),
    .drive_method_write(dwr), .pwm_high_in(ph), .pwm_low_in(pl), .energized_high(eh),
    .energized_low(el), .pump_enable(pe), .fault_status_one(st),
    .fault_live_monitor_one(lv), .alarm_n(an), .drive_method(dm), .gate_high_out(gh),
    .gate_low_out(gl));
  // ********
  // Helpers
  // ********
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [5:0] gx(logic [2:0] p, logic [2:0] h, logic [2:0] l);
    return {p & h, l & ~h};
  endfunction : gx
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk(pe, 1'b0);
    repeat (4) @(negedge clk);
    chk(dm, GSC_DRIVE_PWM);
    chk(pe, 1'b1);
    for (int i = 0; i < 10; i++)
    begin
      r = rnd();
      en = r[4:0];
      f = r[9:5] | (5'h01 << (i % 5));
      cmp = f;
      sclr = i[0];
      repeat (4) @(negedge clk);
      chk(st ^ cmp, 5'h1F);
      chk(lv ^ cmp, 5'h1F);
      chk(an, !(|(en & cmp)));
      cmp = 5'h00;
      sclr = 1'b0;
      repeat (5) @(negedge clk);
      chk({an, st}, {!(|(en & f)), ~f});
      sclr = 1'b1;
      repeat (5) @(negedge clk);
      chk({an, st}, 6'h3F);
      sclr = 1'b0;
    end
    for (int i = 0; i < 8; i++)
    begin
      r = rnd();
      {ph, pl, eh, el} = r[11:0];
      @(negedge clk);
      chk({gh, gl}, {ph, pl});
    end
    dsel = 1'b1;
    dwr = 1'b1;
    @(negedge clk);
    dwr = 1'b0;
    chk(dm, GSC_DRIVE_COMM);
    for (int i = 0; i < 16; i++)
    begin
      r = rnd();
      {ph, pl, eh, el} = r[11:0];
      @(negedge clk);
      chk({gh, gl}, gx(ph, eh, el));
    end
    srst = 1'b1;
    repeat (2) @(negedge clk);
    chk(dm, GSC_DRIVE_PWM);
    chk(pe, 1'b0);
    chk({an, st}, 6'h3F);
    chk({gh, gl}, 6'h00);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk(pe, 1'b1);
    chk(dm, GSC_DRIVE_PWM);
    end_sim();
  end
endmodule : test_gsc_top
`default_nettype wire
